// ==== src/crload_pkg.sv ====
// Constants for the calibration record loader.
// Assumes a byte-addressed information flash read as 16-bit words.
package crload_pkg;
    localparam int ADDR_W = 16;
    localparam logic [15:0] SEG_BASE = 16'h10c0;
    localparam logic [15:0] FIRST_REC = 16'h10c2;
    localparam logic [15:0] SEG_LAST = 16'h10ff;
    localparam logic [5:0] COVERED_WORDS = 6'h1f;
    localparam logic [7:0] TAG_UNUSED = 8'hfe;
    localparam logic [7:0] TAG_OSC = 8'h01;
    localparam logic [7:0] TAG_CONV = 8'h08;
    // Fixed address of the oscillator record tag.
    localparam logic [15:0] OSC_TAG_ADDR = 16'h10f6;
    localparam logic [15:0] HDR_BYTES = 16'h0002;
    localparam logic [15:0] CONV_GAIN_OFS = 16'h0000;
    localparam logic [15:0] CONV_OFFSET_OFS = 16'h0002;
    localparam logic [15:0] CONV_LOREF_OFS = 16'h0004;
    localparam logic [15:0] CONV_HIREF_OFS = 16'h000a;
    localparam logic [7:0] TAP_LOWEST = 8'h00;
    localparam int FACTOR_SHIFT = 16;
    typedef enum logic [1:0] {
        CRLOAD_F16M = 2'h0,
        CRLOAD_F12M = 2'h1,
        CRLOAD_F8M = 2'h2,
        CRLOAD_F1M = 2'h3
    } crload_freq_t;
endpackage

// ==== src/crload_top.sv ====
// Calibration record loader: checksum, record walk, oscillator load and
// converter result correction. Assumes a word flash read port that
// answers a request with an acknowledge after any number of clocks.
`timescale 1ns/1ps
`default_nettype none
module crload_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Control
    input wire logic i_start,
    input wire logic [1:0] i_freq_sel,
    // Flash read port
    output logic o_fl_req,
    output logic [15:0] o_fl_addr,
    input wire logic i_fl_ack,
    input wire logic [15:0] i_fl_data,
    // Clock generator registers
    output logic [7:0] o_clock_range_select_reg,
    output logic [7:0] o_oscillator_tap_mod_reg,
    output logic o_osc_wr,
    // Converter result path
    input wire logic i_raw_valid,
    input wire logic [11:0] i_raw,
    input wire logic i_high_reference_select,
    input wire logic i_use_ref,
    input wire logic i_use_gain,
    input wire logic i_use_offset,
    output logic o_cor_valid,
    output logic [15:0] o_cor,
    // Status
    output logic o_busy,
    output logic o_done,
    output logic o_chk_err,
    output logic o_conv_found
);
    typedef enum logic [7:0] {
        S_IDLE = 8'h01,
        S_SUM = 8'h02,
        S_TAG = 8'h04,
        S_DATA = 8'h08,
        S_CLR = 8'h10,
        S_RANGE = 8'h20,
        S_TAP = 8'h40,
        S_FIN = 8'h80
    } crload_state_t;

    crload_state_t state;
    logic [15:0] addr;
    logic [15:0] acc;
    logic [15:0] stored_sum;
    logic [5:0] wcnt;
    logic [15:0] rec_addr;
    logic [7:0] rec_len;
    logic [2:0] didx;
    logic [7:0] range_byte;
    logic [7:0] tap_byte;
    logic [15:0] gain_f;
    logic [15:0] offs;
    logic [15:0] loref_f;
    logic [15:0] hiref_f;
    logic first_word;

    // Byte within a word: low byte at even address.
    function automatic logic [7:0] byte_of(input logic [15:0] w,
                                           input logic [15:0] a);
        byte_of = a[0] ? w[15:8] : w[7:0];
    endfunction

    // Oscillator pair base offset for the chosen frequency.
    function automatic logic [15:0] osc_pair(input logic [1:0] f);
        osc_pair = {13'h0000, f, 1'b0};
    endfunction

    logic [15:0] next_rec;
    assign next_rec = rec_addr + crload_pkg::HDR_BYTES +
        {8'h00, rec_len};

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            state <= S_IDLE;
            addr <= crload_pkg::SEG_BASE;
            acc <= 16'h0000;
            stored_sum <= 16'h0000;
            wcnt <= 6'h00;
            rec_addr <= crload_pkg::FIRST_REC;
            rec_len <= 8'h00;
            didx <= 3'h0;
            range_byte <= 8'h00;
            tap_byte <= 8'h00;
            gain_f <= 16'h8000;
            offs <= 16'h0000;
            loref_f <= 16'h8000;
            hiref_f <= 16'h8000;
            first_word <= 1'b1;
            o_fl_req <= 1'b0;
            o_fl_addr <= 16'h0000;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_chk_err <= 1'b0;
            o_conv_found <= 1'b0;
            o_osc_wr <= 1'b0;
            o_clock_range_select_reg <= 8'h00;
            o_oscillator_tap_mod_reg <= 8'h00;
        end else begin
            o_osc_wr <= 1'b0;
            unique case (state)
                S_IDLE: begin
                    if (i_start) begin
                        state <= S_SUM;
                        o_busy <= 1'b1;
                        o_done <= 1'b0;
                        o_chk_err <= 1'b0;
                        o_conv_found <= 1'b0;
                        acc <= 16'h0000;
                        wcnt <= 6'h00;
                        first_word <= 1'b1;
                        o_fl_req <= 1'b1;
                        o_fl_addr <= crload_pkg::SEG_BASE;
                        addr <= crload_pkg::SEG_BASE;
                    end
                end
                S_SUM: begin
                    if (i_fl_ack) begin
                        if (first_word) begin
                            stored_sum <= i_fl_data;
                            first_word <= 1'b0;
                        end else begin
                            acc <= acc ^ i_fl_data;
                            wcnt <= wcnt + 6'h01;
                        end
                        if (!first_word &&
                            wcnt == crload_pkg::COVERED_WORDS - 6'h01) begin
                            // Sum of XOR and stored word must be zero.
                            if (16'((acc ^ i_fl_data) + stored_sum)
                                != 16'h0000) begin
                                o_chk_err <= 1'b1;
                                o_fl_req <= 1'b0;
                                state <= S_FIN;
                            end else begin
                                rec_addr <= crload_pkg::FIRST_REC;
                                o_fl_addr <= crload_pkg::FIRST_REC;
                                state <= S_TAG;
                            end
                        end else begin
                            o_fl_addr <= addr + 16'h0002;
                            addr <= addr + 16'h0002;
                        end
                    end
                end
                S_TAG: begin
                    if (i_fl_ack) begin
                        rec_len <= i_fl_data[15:8];
                        didx <= 3'h0;
                        if (i_fl_data[7:0] == crload_pkg::TAG_CONV) begin
                            o_fl_addr <= rec_addr + crload_pkg::HDR_BYTES;
                            state <= S_DATA;
                        end else begin
                            // Unused and oscillator records are skipped here.
                            rec_addr <= rec_addr + crload_pkg::HDR_BYTES +
                                {8'h00, i_fl_data[15:8]};
                            o_fl_addr <= rec_addr + crload_pkg::HDR_BYTES +
                                {8'h00, i_fl_data[15:8]};
                            if (rec_addr + crload_pkg::HDR_BYTES +
                                {8'h00, i_fl_data[15:8]} >=
                                crload_pkg::SEG_LAST) begin
                                o_fl_addr <= crload_pkg::OSC_TAG_ADDR +
                                    crload_pkg::HDR_BYTES +
                                    osc_pair(i_freq_sel);
                                state <= S_CLR;
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (i_fl_ack) begin
                        unique case (didx)
                            3'h0: gain_f <= i_fl_data;
                            3'h1: offs <= i_fl_data;
                            3'h2: loref_f <= i_fl_data;
                            3'h5: hiref_f <= i_fl_data;
                            default: ;
                        endcase
                        didx <= didx + 3'h1;
                        o_fl_addr <= o_fl_addr + 16'h0002;
                        if (didx == 3'h7) begin
                            o_conv_found <= 1'b1;
                            rec_addr <= next_rec;
                            o_fl_addr <= next_rec;
                            state <= S_TAG;
                            if (next_rec >= crload_pkg::SEG_LAST) begin
                                o_fl_addr <= crload_pkg::OSC_TAG_ADDR +
                                    crload_pkg::HDR_BYTES +
                                    osc_pair(i_freq_sel);
                                state <= S_CLR;
                            end
                        end
                    end
                end
                S_CLR: begin
                    if (i_fl_ack) begin
                        tap_byte <= byte_of(i_fl_data, 16'h0000);
                        range_byte <= byte_of(i_fl_data, 16'h0001);
                        o_fl_req <= 1'b0;
                        o_oscillator_tap_mod_reg <=
                            crload_pkg::TAP_LOWEST;
                        o_osc_wr <= 1'b1;
                        state <= S_RANGE;
                    end
                end
                S_RANGE: begin
                    o_clock_range_select_reg <= range_byte;
                    o_osc_wr <= 1'b1;
                    state <= S_TAP;
                end
                S_TAP: begin
                    o_oscillator_tap_mod_reg <= tap_byte;
                    o_osc_wr <= 1'b1;
                    state <= S_FIN;
                end
                S_FIN: begin
                    o_busy <= 1'b0;
                    o_done <= 1'b1;
                    o_fl_req <= 1'b0;
                    state <= S_IDLE;
                end
            endcase
        end
    end

    // Result correction: two pipeline stages. Corrections are only applied
    // once a good segment is loaded; the raw value passes otherwise.
    logic cal_ok;
    assign cal_ok = o_done && !o_chk_err && o_conv_found;
    logic [15:0] ref_f;
    assign ref_f = i_high_reference_select ? hiref_f : loref_f;
    logic [15:0] dbl;
    assign dbl = {3'h0, i_raw, 1'b0};
    logic [31:0] p_ref;
    logic [31:0] p_gain;
    assign p_ref = dbl * ref_f;
    logic [15:0] mid;
    logic mid_valid;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            mid <= 16'h0000;
            mid_valid <= 1'b0;
        end else begin
            mid_valid <= i_raw_valid;
            if (i_raw_valid) begin
                mid <= (cal_ok && i_use_ref) ?
                    p_ref[31:crload_pkg::FACTOR_SHIFT] : {4'h0, i_raw};
            end
        end
    end

    // Gain stage works on the reference-corrected value, offset after it.
    logic [15:0] dbl_mid;
    assign dbl_mid = {mid[14:0], 1'b0};
    assign p_gain = dbl_mid * gain_f;
    logic [15:0] gained;
    assign gained = (cal_ok && i_use_gain) ?
        p_gain[31:crload_pkg::FACTOR_SHIFT] : mid;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_cor <= 16'h0000;
            o_cor_valid <= 1'b0;
        end else begin
            o_cor_valid <= mid_valid;
            if (mid_valid) begin
                o_cor <= (cal_ok && i_use_offset) ?
                    gained + offs : gained;
            end
        end
    end

    chk_sum_gate: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_chk_err |-> !o_osc_wr)
        else $error("oscillator written after checksum error");
    chk_clear_first: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        state == S_RANGE |-> o_oscillator_tap_mod_reg ==
            crload_pkg::TAP_LOWEST)
        else $error("tap not cleared before range write");
    chk_seq_order: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        state == S_RANGE |=> state == S_TAP ##1 state == S_FIN)
        else $error("oscillator write order broken");
    chk_tap_load: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        state == S_TAP |=> o_oscillator_tap_mod_reg == $past(tap_byte))
        else $error("tap byte not loaded");
    chk_walk_start: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(state == S_TAG) && $past(state) == S_SUM
        |-> o_fl_addr == crload_pkg::FIRST_REC)
        else $error("walk not started at first record");
    chk_pipe_lat: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_raw_valid |-> ##2 o_cor_valid)
        else $error("corrected result latency wrong");
    chk_pass_raw: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        i_raw_valid && !cal_ok ##1 !cal_ok
        |=> o_cor == {4'h0, $past(i_raw, 2)})
        else $error("raw value not passed without calibration");
    chk_done_idle: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        state == S_FIN |=> o_done && !o_busy)
        else $error("done flag not raised");
    // A failed segment must still end the load, or software waits forever.
    chk_err_done: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        $rose(o_chk_err) |=> o_done && !o_busy)
        else $error("checksum error did not end the load");
    chk_req_busy: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        o_fl_req |-> o_busy)
        else $error("flash read requested while idle");
    chk_three_writes: assert property (
        @(posedge i_clk) disable iff (!i_rst_b)
        state == S_CLR && i_fl_ack |=> o_osc_wr [*3] ##1 !o_osc_wr)
        else $error("oscillator write burst not three cycles");
endmodule
`default_nettype wire

// ==== tb/crload_flash_model.sv ====
// Behavioural information flash holding one calibration segment.
// Assumes word reads at even byte addresses inside that segment.
`timescale 1ns/1ps
`default_nettype none
module crload_flash_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Read port
    input wire logic i_req,
    input wire logic [15:0] i_addr,
    output logic o_ack,
    output logic [15:0] o_data,
    // Extra answer delay in cycles
    input wire logic [1:0] i_wait
);
    logic [15:0] mem [0:31];
    logic [1:0] cnt;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_ack <= 1'b0;
            o_data <= 16'h5a5a;
            cnt <= 2'h0;
        end else if (i_req && !o_ack && cnt == i_wait) begin
            o_ack <= 1'b1;
            o_data <= mem[i_addr[5:1]];
            cnt <= 2'h0;
        end else begin
            // Stale data is inverted every idle cycle, so a sampler one cycle late sees its complement.
            o_ack <= 1'b0;
            o_data <= ~o_data;
            if (i_req && !o_ack) begin
                cnt <= cnt + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/tb_crload_top.sv ====
// Self-checking bench for the calibration record loader.
// Assumes the flash model of this folder answers the read port.
`timescale 1ns/1ps
`default_nettype none
module tb_crload_top;
    logic clk, rst_b, start, raw_valid, hi_sel, use_ref, use_gain, use_offset;
    logic fl_req, fl_ack, osc_wr, cor_valid, busy, done, chk_err, conv_found;
    logic [1:0] freq, fwait;
    logic [11:0] raw;
    logic [15:0] fl_addr, fl_data, cor, gain, offs, lof, hif, x;
    logic [15:0] exp_cor, exp_osc;
    logic [7:0] rng, tap, last_range;
    logic [15:0] img [0:31];
    logic [15:0] cor_q[$], osc_q[$], addr_q[$];
    int mismatches, num_checks, cycles, osc_writes, reads;

    crload_top uut (.i_clk(clk), .i_rst_b(rst_b), .i_start(start),
        .i_freq_sel(freq), .o_fl_req(fl_req), .o_fl_addr(fl_addr),
        .i_fl_ack(fl_ack), .i_fl_data(fl_data),
        .o_clock_range_select_reg(rng), .o_oscillator_tap_mod_reg(tap),
        .o_osc_wr(osc_wr), .i_raw_valid(raw_valid), .i_raw(raw),
        .i_high_reference_select(hi_sel), .i_use_ref(use_ref),
        .i_use_gain(use_gain), .i_use_offset(use_offset),
        .o_cor_valid(cor_valid), .o_cor(cor), .o_busy(busy), .o_done(done),
        .o_chk_err(chk_err), .o_conv_found(conv_found));
    crload_flash_model flash (.i_clk(clk), .i_rst_b(rst_b), .i_req(fl_req),
        .i_addr(fl_addr), .o_ack(fl_ack), .o_data(fl_data), .i_wait(fwait));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic [15:0] scale(input logic [15:0] v, f);
        logic [31:0] p;
        p = {v[14:0], 1'b0} * {16'h0000, f};
        return p[31:16];
    endfunction

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            mismatches++;
            $display("ERROR %0t: run did not finish", $time);
            report_and_stop();
        end
    end

    // Results and register writes are pulses, so they are taken mid-cycle.
    always @(negedge clk) begin
        if (cor_valid === 1'b1) begin
            exp_cor = cor_q.size() ? cor_q.pop_front() : 16'hxxxx;
            chk(cor, exp_cor);
        end
        if (osc_wr === 1'b1) begin
            osc_writes++;
            exp_osc = osc_q.size() ? osc_q.pop_front() : 16'hxxxx;
            chk({rng, tap}, exp_osc);
        end
        if (fl_req === 1'b1 && fl_ack === 1'b1) begin
            reads++;
            if (addr_q.size()) begin
                chk(fl_addr, addr_q.pop_front());
            end
        end
    end

    task automatic do_reset;
        rst_b = 1'b0;
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        last_range = 8'h00;
        chk({rng, tap}, 16'h0000);
        chk(cor, 16'h0000);
        chk({9'h000, cor_valid, osc_wr, busy, done, chk_err, conv_found,
             fl_req}, 16'h0000);
    endtask

    task automatic load(input bit bad);
        for (int i = 1; i < 32; i++) img[i] = 16'($urandom);
        gain = 16'h7000 + 16'($urandom & 32'h1fff);
        lof = 16'h7000 + 16'($urandom & 32'h1fff);
        hif = 16'h7000 + 16'($urandom & 32'h1fff);
        offs = 16'hfff0 + 16'($urandom & 32'h1f);
        img[1] = {8'h16, crload_pkg::TAG_UNUSED};
        img[13] = {8'h10, crload_pkg::TAG_CONV};
        img[14] = gain;
        img[15] = offs;
        img[16] = lof;
        img[19] = hif;
        img[22] = {8'h08, crload_pkg::TAG_UNUSED};
        img[27] = {8'h08, crload_pkg::TAG_OSC};
        x = 16'h0000;
        for (int i = 1; i < 32; i++) x = x ^ img[i];
        img[0] = (16'h0000 - x) ^ (bad ? 16'h0100 : 16'h0000);
        for (int i = 0; i < 32; i++) flash.mem[i] = img[i];
        freq = 2'($urandom);
        for (int i = 0; i < 32; i++) addr_q.push_back(16'h10c0 + 16'(2 * i));
        if (!bad) begin
            addr_q.push_back(16'h10c2);
            addr_q.push_back(16'h10da);
            for (int i = 0; i < 8; i++) begin
                addr_q.push_back(16'h10dc + 16'(2 * i));
            end
            addr_q.push_back(16'h10ec);
            addr_q.push_back(16'h10f6);
            addr_q.push_back(16'h10f8 + {13'h0000, freq, 1'b0});
            osc_q.push_back({last_range, crload_pkg::TAP_LOWEST});
            osc_q.push_back({img[28 + freq][15:8], crload_pkg::TAP_LOWEST});
            osc_q.push_back(img[28 + freq]);
            last_range = img[28 + freq][15:8];
        end
        osc_writes = 0;
        reads = 0;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (2) @(negedge clk);
        for (int n = 0; n < 600 && busy !== 1'b0; n++) @(negedge clk);
        chk({15'h0000, chk_err}, {15'h0000, bad});
        chk({14'h0000, busy, done}, 16'h0001);
        chk(16'(osc_writes), bad ? 16'h0000 : 16'h0003);
        chk(16'(reads), bad ? 16'h0020 : 16'h002d);
        if (!bad) begin
            chk({14'h0000, done, conv_found}, 16'h0003);
            chk(16'(addr_q.size() + osc_q.size()), 16'h0000);
        end
        addr_q.delete();
    endtask

    task automatic conv(input bit corr);
        logic [15:0] v;
        for (int c = 0; c < 16; c++) begin
            {hi_sel, use_ref, use_gain, use_offset} = 4'(c);
            for (int k = 0; k < 3; k++) begin
                raw = 12'h040 | 12'($urandom);
                raw_valid = 1'b1;
                v = {4'h0, raw};
                if (corr && use_ref) v = scale(v, hi_sel ? hif : lof);
                if (corr && use_gain) v = scale(v, gain);
                if (corr && use_offset) v = v + offs;
                cor_q.push_back(v);
                @(negedge clk);
            end
            raw_valid = 1'b0;
            repeat (4) @(negedge clk);
        end
        chk(16'(cor_q.size()), 16'h0000);
    endtask

    initial begin
        {rst_b, start, raw_valid, hi_sel, use_ref, use_gain, use_offset} = '0;
        freq = 2'h0;
        fwait = 2'h0;
        raw = 12'h000;
        void'($urandom(32'h714b));
        @(negedge clk);
        do_reset();
        conv(1'b0);
        fwait = 2'h2;
        load(1'b1);
        conv(1'b0);
        do_reset();
        fwait = 2'h0;
        load(1'b0);
        conv(1'b1);
        fwait = 2'h1;
        load(1'b0);
        conv(1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire
